// File: hdl/psp_pkg.sv
// Purpose: Shared constants and carrier types for the serial/second port pin mux
// Assumes: 32-bit APB register words, byte offsets below
// Notes: All reset values are zero so every pin starts as plain GPIO
package psp_pkg;
  localparam int SER_W = 6;
  localparam int SEC_W = 3;
  localparam int ST_W = 10;

  localparam logic [11:0] ROUTE_A_OFS = 12'h000;
  localparam logic [11:0] ROUTE_B_OFS = 12'h004;
  localparam logic [11:0] IRQ_CTRL_OFS = 12'h008;
  localparam logic [11:0] MISC_OFS = 12'h00c;
  localparam logic [11:0] CLKOUT_OFS = 12'h010;
  localparam logic [11:0] SER_DATA_OFS = 12'h020;
  localparam logic [11:0] SER_IN_OFS = 12'h024;
  localparam logic [11:0] SER_DIR_OFS = 12'h028;
  localparam logic [11:0] SEC_DATA_OFS = 12'h040;
  localparam logic [11:0] SEC_IN_OFS = 12'h044;
  localparam logic [11:0] SEC_DIR_OFS = 12'h048;
  localparam logic [11:0] EDGE_POL_OFS = 12'h060;
  localparam logic [11:0] STATUS_OFS = 12'h064;
  localparam logic [11:0] MASK_OFS = 12'h068;
  localparam logic [11:0] PIN_STATE_OFS = 12'h06c;

  // Route A: select/route bits as in the mode routing byte
  localparam int SPI_SS_RR_BIT = 5;
  localparam int SPI_RR_BIT = 4;
  localparam int UART1_RR_BIT = 3;
  localparam int LIN_RR_LSB = 0;
  localparam logic [2:0] LIN_ROUTE_CODE = 3'h1;
  // Route B: pwm routing
  localparam int PWM_PORT_RR_BIT = 3;
  localparam int PWM_MID_RR_BIT = 1;
  localparam int PWM_LOW_RR_BIT = 0;
  localparam int IRQ_EDGE_BIT = 1;
  localparam int IRQ_EN_BIT = 0;
  localparam int OCP_EN_BIT = 1;
  localparam int CLKOUT_EN_BIT = 0;
  localparam int ST_SER_LSB = 0;
  localparam int ST_SEC_LSB = 6;
  localparam int ST_OC_BIT = 9;

  localparam logic [5:0] ROUTE_A_RST = 6'h00;
  localparam logic [3:0] ROUTE_B_RST = 4'h0;
  localparam logic [1:0] IRQ_CTRL_RST = 2'h0;
  localparam logic [SER_W-1:0] SER_RST = 6'h00;
  localparam logic [SEC_W-1:0] SEC_RST = 3'h0;
  localparam logic [ST_W-1:0] ST_RST = 10'h000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } psp_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } psp_apb_rsp_type;

  // Index order of spi lanes: 0 select, 1 clock, 2 host out, 3 host in
  typedef struct packed {
    logic prof_en;
    logic prof_data;
    logic prof_clk;
    logic spi_en;
    logic [3:0] spi_out;
    logic [3:0] spi_drive;
    logic uart1_en;
    logic uart1_tx;
    logic lin_en;
    logic lin_rx_out;
    logic can_en;
    logic can_tx;
    logic [1:0] trig_en;
    logic [1:0] trig;
    logic dbg_event_en;
    logic [2:0] pwm_en;
    logic [2:0] pwm;
    logic fault_en;
  } psp_periph_out_type;

  typedef struct packed {
    logic [3:0] spi_in;
    logic uart1_rx;
    logic lin_tx_in;
    logic can_rx;
    logic dbg_event;
    logic fault;
  } psp_periph_in_type;
endpackage

// File: hdl/psp_sync_edge.sv
// Purpose: Two-stage synchroniser with edge pulses for a group of pins
// Assumes: Pins are asynchronous to clock_i
// Notes: Edge pulses lag the pin by two clocks
`timescale 1ns/1ps
module psp_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] prev;
  } psp_sync_state_type;

  psp_sync_state_type s_q;
  psp_sync_state_type s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d.meta = pin_i;
    s_d.lvl = s_q.meta;
    s_d.prev = s_q.lvl;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.lvl;
  assign rise_o = s_q.lvl & ~s_q.prev;
  assign fall_o = ~s_q.lvl & s_q.prev;
endmodule

// File: hdl/psp_pin_mux.sv
// Purpose: Pin function mux for the six-pin serial port and three-pin second port
// Assumes: APB slave, zero wait state; peripherals and cpu flags on clock_i
// Notes: Pin outputs lag the selecting inputs by one clock
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module psp_pin_mux (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire psp_pkg::psp_apb_req_type apb_i,
  output psp_pkg::psp_apb_rsp_type apb_o,
  input wire psp_pkg::psp_periph_out_type periph_i,
  output psp_pkg::psp_periph_in_type periph_o,
  input wire logic x_mask_i,
  input wire logic irq_ack_i,
  input wire logic overcurrent_i,
  input wire logic [psp_pkg::SER_W-1:0] serial_pin_i,
  output logic [psp_pkg::SER_W-1:0] serial_pin_o,
  output logic [psp_pkg::SER_W-1:0] serial_pin_oe_n_o,
  input wire logic [psp_pkg::SEC_W-1:0] second_pin_i,
  output logic [psp_pkg::SEC_W-1:0] second_pin_o,
  output logic [psp_pkg::SEC_W-1:0] second_pin_oe_n_o,
  output logic irq_o,
  output logic irq_req_o,
  output logic nmi_req_o,
  output logic wake_o
);
  typedef struct packed {
    logic [5:0] route_a;
    logic [3:0] route_b;
    logic [1:0] irq_ctrl;
    logic ocp_en;
    logic clkout_en;
    logic [psp_pkg::SER_W-1:0] ser_data;
    logic [psp_pkg::SER_W-1:0] ser_dir;
    logic [psp_pkg::SEC_W-1:0] sec_data;
    logic [psp_pkg::SEC_W-1:0] sec_dir;
    logic [psp_pkg::ST_W-2:0] edge_pol;
    logic [psp_pkg::ST_W-1:0] status;
    logic [psp_pkg::ST_W-1:0] mask;
    logic nmi_armed;
    logic irq_pend;
    logic clk_div;
    logic [psp_pkg::SER_W-1:0] ser_pin;
    logic [psp_pkg::SER_W-1:0] ser_oe_n;
    logic [psp_pkg::SEC_W-1:0] sec_pin;
    logic [psp_pkg::SEC_W-1:0] sec_oe_n;
    logic irq;
    logic irq_req;
    logic nmi_req;
    logic wake;
    psp_pkg::psp_periph_in_type pin_in;
    psp_pkg::psp_apb_rsp_type rsp;
  } psp_state_type;

  psp_state_type s_q;
  psp_state_type s_d;
  logic [psp_pkg::SER_W-1:0] ser_lvl, ser_rise, ser_fall;
  logic [psp_pkg::SEC_W-1:0] sec_lvl, sec_rise, sec_fall;
  logic oc_lvl, oc_rise;
  logic [psp_pkg::ST_W-2:0] key_hit;
  logic oc_event;
  logic spi_here;
  logic wr;
  logic [psp_pkg::SER_W-1:0] so, sd;
  logic [psp_pkg::SEC_W-1:0] po, pd;

  psp_sync_edge #(.WIDTH(psp_pkg::SER_W)) u_ser_sync (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(serial_pin_i),
    .level_o(ser_lvl), .rise_o(ser_rise), .fall_o(ser_fall));
  psp_sync_edge #(.WIDTH(psp_pkg::SEC_W)) u_sec_sync (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(second_pin_i),
    .level_o(sec_lvl), .rise_o(sec_rise), .fall_o(sec_fall));
  psp_sync_edge #(.WIDTH(1)) u_oc_sync (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(overcurrent_i),
    .level_o(oc_lvl), .rise_o(oc_rise), .fall_o());

  // Polarity bit set selects rising edge, clear selects falling
  assign key_hit = (s_q.edge_pol & {sec_rise, ser_rise}) | (~s_q.edge_pol & {sec_fall, ser_fall});
  // Only counts while pin zero actually sources current
  assign oc_event = oc_rise & s_q.ocp_en & ~s_q.sec_oe_n[0] & s_q.sec_pin[0];
  assign spi_here = periph_i.spi_en & ~s_q.route_a[psp_pkg::SPI_RR_BIT];
  assign wr = apb_i.psel & apb_i.penable & apb_i.pwrite & s_q.rsp.pready;

  always_comb begin
    s_d = s_q;
    // Serial port, priority from top to bottom, GPIO last
    so = s_q.ser_data;
    sd = s_q.ser_dir;
    if (periph_i.prof_en) begin
      so[5] = periph_i.prof_data;
      sd[5] = 1'b1;
    end else if (spi_here & ~s_q.route_a[psp_pkg::SPI_SS_RR_BIT]) begin
      so[5] = periph_i.spi_out[0];
      sd[5] = periph_i.spi_drive[0];
    end
    if (periph_i.prof_en) begin
      so[4] = periph_i.prof_clk;
      sd[4] = 1'b1;
    end else if (spi_here) begin
      so[4] = periph_i.spi_out[1];
      sd[4] = periph_i.spi_drive[1];
    end
    if (spi_here) begin
      so[3] = periph_i.spi_out[2];
      sd[3] = periph_i.spi_drive[2];
      so[2] = periph_i.spi_out[3];
      sd[2] = periph_i.spi_drive[3];
    end else if (periph_i.uart1_en & s_q.route_a[psp_pkg::UART1_RR_BIT]) begin
      so[3] = periph_i.uart1_tx;
      sd[3] = 1'b1;
      sd[2] = 1'b0;
    end else if (periph_i.dbg_event_en) begin
      sd[3] = 1'b0;
    end
    if (periph_i.trig_en[1]) begin
      so[1] = periph_i.trig[1];
      sd[1] = 1'b1;
    end else if (periph_i.lin_en & (s_q.route_a[2:0] == psp_pkg::LIN_ROUTE_CODE)) begin
      sd[1] = 1'b0;
    end else if (periph_i.can_en) begin
      so[1] = periph_i.can_tx;
      sd[1] = 1'b1;
    end else if (periph_i.uart1_en & ~s_q.route_a[psp_pkg::UART1_RR_BIT]) begin
      so[1] = periph_i.uart1_tx;
      sd[1] = 1'b1;
    end
    if (periph_i.trig_en[0]) begin
      so[0] = periph_i.trig[0];
      sd[0] = 1'b1;
    end else if (periph_i.lin_en & (s_q.route_a[2:0] == psp_pkg::LIN_ROUTE_CODE)) begin
      so[0] = periph_i.lin_rx_out;
      sd[0] = 1'b1;
    end else if (periph_i.can_en | (periph_i.uart1_en & ~s_q.route_a[psp_pkg::UART1_RR_BIT])) begin
      sd[0] = 1'b0;
    end
    // Second port
    po = s_q.sec_data;
    pd = s_q.sec_dir;
    if (periph_i.pwm_en[2] & s_q.route_b[psp_pkg::PWM_MID_RR_BIT] & s_q.route_b[psp_pkg::PWM_PORT_RR_BIT]) begin
      po[2] = periph_i.pwm[2];
      pd[2] = 1'b1;
    end
    if (s_q.irq_ctrl[psp_pkg::IRQ_EN_BIT]) begin
      pd[1] = 1'b0;
    end else if (periph_i.pwm_en[1] & s_q.route_b[psp_pkg::PWM_LOW_RR_BIT]
                 & s_q.route_b[psp_pkg::PWM_PORT_RR_BIT]) begin
      po[1] = periph_i.pwm[1];
      pd[1] = 1'b1;
    end
    // Once armed the pin stays an input whatever software writes
    if (s_q.nmi_armed | periph_i.fault_en) begin
      pd[0] = 1'b0;
    end else if (s_q.clkout_en) begin
      po[0] = s_q.clk_div;
      pd[0] = 1'b1;
    end else if (periph_i.pwm_en[0] & s_q.route_b[psp_pkg::PWM_LOW_RR_BIT]
                 & s_q.route_b[psp_pkg::PWM_PORT_RR_BIT]) begin
      po[0] = periph_i.pwm[0];
      pd[0] = 1'b1;
    end
    s_d.ser_pin = so;
    s_d.ser_oe_n = ~sd;
    s_d.sec_pin = po;
    s_d.sec_oe_n = ~pd;
    s_d.clk_div = s_q.clkout_en & ~s_q.clk_div;

    s_d.pin_in.spi_in = {ser_lvl[2], ser_lvl[3], ser_lvl[4], ser_lvl[5]};
    s_d.pin_in.uart1_rx = s_q.route_a[psp_pkg::UART1_RR_BIT] ? ser_lvl[2] : ser_lvl[0];
    s_d.pin_in.lin_tx_in = ser_lvl[1];
    s_d.pin_in.can_rx = ser_lvl[0];
    s_d.pin_in.dbg_event = ser_lvl[3];
    s_d.pin_in.fault = sec_lvl[0];

    // Register writes; a hardware set beats a write-one clear
    if (wr) begin
      unique case (apb_i.paddr)
        psp_pkg::ROUTE_A_OFS: s_d.route_a = apb_i.pwdata[5:0];
        psp_pkg::ROUTE_B_OFS: s_d.route_b = apb_i.pwdata[3:0];
        psp_pkg::IRQ_CTRL_OFS: s_d.irq_ctrl = apb_i.pwdata[1:0];
        psp_pkg::MISC_OFS: s_d.ocp_en = apb_i.pwdata[psp_pkg::OCP_EN_BIT];
        psp_pkg::CLKOUT_OFS: s_d.clkout_en = apb_i.pwdata[psp_pkg::CLKOUT_EN_BIT];
        psp_pkg::SER_DATA_OFS: s_d.ser_data = apb_i.pwdata[psp_pkg::SER_W-1:0];
        psp_pkg::SER_DIR_OFS: s_d.ser_dir = apb_i.pwdata[psp_pkg::SER_W-1:0];
        psp_pkg::SEC_DATA_OFS: s_d.sec_data = apb_i.pwdata[psp_pkg::SEC_W-1:0];
        psp_pkg::SEC_DIR_OFS: s_d.sec_dir = apb_i.pwdata[psp_pkg::SEC_W-1:0];
        psp_pkg::EDGE_POL_OFS: s_d.edge_pol = apb_i.pwdata[psp_pkg::ST_W-2:0];
        psp_pkg::STATUS_OFS: s_d.status = s_q.status & ~apb_i.pwdata[psp_pkg::ST_W-1:0];
        psp_pkg::MASK_OFS: s_d.mask = apb_i.pwdata[psp_pkg::ST_W-1:0];
        default: s_d.mask = s_q.mask;
      endcase
    end
    s_d.status = s_d.status | {oc_event, key_hit};

    // Armed on the first cleared X bit, held until reset
    s_d.nmi_armed = s_q.nmi_armed | ~x_mask_i;
    s_d.nmi_req = s_d.nmi_armed & ~sec_lvl[0];
    s_d.irq_pend = s_q.irq_ctrl[psp_pkg::IRQ_EN_BIT] & ((s_q.irq_pend & ~irq_ack_i) | sec_fall[1]);
    s_d.irq_req = s_q.irq_ctrl[psp_pkg::IRQ_EN_BIT]
                  & (s_q.irq_ctrl[psp_pkg::IRQ_EDGE_BIT] ? s_d.irq_pend : ~sec_lvl[1]);
    s_d.irq = |(s_d.status & s_d.mask);
    // Non-maskable source wakes only through the armed request
    s_d.wake = s_d.irq | s_d.irq_req | s_d.nmi_req;

    // Read data is prepared in the setup phase, answered in the first access cycle
    s_d.rsp.pready = apb_i.psel & ~apb_i.penable;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata = 32'h0000_0000;
    if (apb_i.psel & ~apb_i.penable) begin
      unique case (apb_i.paddr)
        psp_pkg::ROUTE_A_OFS: s_d.rsp.prdata[5:0] = s_q.route_a;
        psp_pkg::ROUTE_B_OFS: s_d.rsp.prdata[3:0] = s_q.route_b;
        psp_pkg::IRQ_CTRL_OFS: s_d.rsp.prdata[1:0] = s_q.irq_ctrl;
        psp_pkg::MISC_OFS: s_d.rsp.prdata[psp_pkg::OCP_EN_BIT] = s_q.ocp_en;
        psp_pkg::CLKOUT_OFS: s_d.rsp.prdata[psp_pkg::CLKOUT_EN_BIT] = s_q.clkout_en;
        psp_pkg::SER_DATA_OFS: s_d.rsp.prdata[psp_pkg::SER_W-1:0] = s_q.ser_data;
        psp_pkg::SER_IN_OFS: s_d.rsp.prdata[psp_pkg::SER_W-1:0] = ser_lvl;
        psp_pkg::SER_DIR_OFS: s_d.rsp.prdata[psp_pkg::SER_W-1:0] = s_q.ser_dir;
        psp_pkg::SEC_DATA_OFS: s_d.rsp.prdata[psp_pkg::SEC_W-1:0] = s_q.sec_data;
        psp_pkg::SEC_IN_OFS: s_d.rsp.prdata[psp_pkg::SEC_W-1:0] = sec_lvl;
        psp_pkg::SEC_DIR_OFS: s_d.rsp.prdata[psp_pkg::SEC_W-1:0] = s_q.sec_dir;
        psp_pkg::EDGE_POL_OFS: s_d.rsp.prdata[psp_pkg::ST_W-2:0] = s_q.edge_pol;
        psp_pkg::STATUS_OFS: s_d.rsp.prdata[psp_pkg::ST_W-1:0] = s_q.status;
        psp_pkg::MASK_OFS: s_d.rsp.prdata[psp_pkg::ST_W-1:0] = s_q.mask;
        psp_pkg::PIN_STATE_OFS: s_d.rsp.prdata[2:0] = {oc_lvl, s_q.irq_pend, s_q.nmi_armed};
        default: s_d.rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.ser_oe_n <= '1;
      s_q.sec_oe_n <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_o = s_q.rsp;
  assign periph_o = s_q.pin_in;
  assign serial_pin_o = s_q.ser_pin;
  assign serial_pin_oe_n_o = s_q.ser_oe_n;
  assign second_pin_o = s_q.sec_pin;
  assign second_pin_oe_n_o = s_q.sec_oe_n;
  assign irq_o = s_q.irq;
  assign irq_req_o = s_q.irq_req;
  assign nmi_req_o = s_q.nmi_req;
  assign wake_o = s_q.wake;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_gpio_default;
    !(periph_i.prof_en | periph_i.spi_en | periph_i.uart1_en | periph_i.lin_en | periph_i.can_en
      | (|periph_i.trig_en) | periph_i.dbg_event_en)
    |=> serial_pin_oe_n_o == ~$past(s_q.ser_dir) && serial_pin_o == $past(s_q.ser_data);
  endproperty
  a_gpio_default: assert property (p_gpio_default) else $error("serial pin left GPIO");

  property p_uart_alt;
    periph_i.uart1_en && s_q.route_a[psp_pkg::UART1_RR_BIT] && !spi_here
    |=> !serial_pin_oe_n_o[3] && serial_pin_o[3] == $past(periph_i.uart1_tx);
  endproperty
  a_uart_alt: assert property (p_uart_alt) else $error("routed uart tx missing");

  property p_prof_wins;
    periph_i.prof_en && periph_i.spi_en |=> serial_pin_o[5] == $past(periph_i.prof_data) && !serial_pin_oe_n_o[5];
  endproperty
  a_prof_wins: assert property (p_prof_wins) else $error("priority lost on serial pin 5");

  property p_key_flag;
    |key_hit |=> (s_q.status[psp_pkg::ST_W-2:0] & $past(key_hit)) == $past(key_hit);
  endproperty
  a_key_flag: assert property (p_key_flag) else $error("key edge flag not set");

  property p_irq_edge;
    s_q.irq_ctrl == 2'h3 && sec_fall[1] |=> irq_req_o && second_pin_oe_n_o[1];
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("falling edge interrupt missed");

  property p_nmi_level;
    s_q.nmi_armed && !sec_lvl[0] |=> nmi_req_o;
  endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("non-maskable level missed");

  property p_nmi_blocked;
    x_mask_i && !s_q.nmi_armed |=> !nmi_req_o;
  endproperty
  a_nmi_blocked: assert property (p_nmi_blocked) else $error("non-maskable request while X set");

  property p_nmi_input;
    s_q.nmi_armed |=> s_q.nmi_armed && second_pin_oe_n_o[0];
  endproperty
  a_nmi_input: assert property (p_nmi_input) else $error("armed pin not held input");

  // Next mask value, since a mask write lands in the same edge as the irq update
  property p_no_wake;
    x_mask_i && !s_q.nmi_armed && !s_q.irq_ctrl[psp_pkg::IRQ_EN_BIT] && s_d.mask == '0 |=> !wake_o;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake without armed source");

  property p_spi_ss;
    spi_here && !s_q.route_a[psp_pkg::SPI_SS_RR_BIT] && !periph_i.prof_en && periph_i.spi_drive[0]
    |=> !serial_pin_oe_n_o[5] && serial_pin_o[5] == $past(periph_i.spi_out[0]);
  endproperty
  a_spi_ss: assert property (p_spi_ss) else $error("spi select not on pin 5");

  property p_oc_flag;
    oc_event |=> s_q.status[psp_pkg::ST_OC_BIT] ##0 (irq_o == |(s_q.status & s_q.mask))[*1];
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("over-current flag missing");

  property p_pwm2;
    periph_i.pwm_en[2] && s_q.route_b[psp_pkg::PWM_MID_RR_BIT] && s_q.route_b[psp_pkg::PWM_PORT_RR_BIT]
    |=> !second_pin_oe_n_o[2] && second_pin_o[2] == $past(periph_i.pwm[2]);
  endproperty
  a_pwm2: assert property (p_pwm2) else $error("routed pwm 2 missing");

  c_nmi_arm: cover property (!s_q.nmi_armed ##1 s_q.nmi_armed);
  c_oc_irq: cover property (oc_event ##[1:3] irq_o);
  c_spi_route: cover property (spi_here && periph_i.spi_drive[1]);
  c_irq_edge: cover property (irq_req_o && s_q.irq_ctrl[psp_pkg::IRQ_EDGE_BIT]);
endmodule

// File: verif/psp_board_model.sv
// Purpose: Board side of the pads for one port
// Assumes: No pull resistors on these board nets
// Notes: The board level shows only where the design has released the pad
`timescale 1ns/1ps
module psp_board_model #(
  parameter int WIDTH = 1
) (
  input wire logic [WIDTH-1:0] pin_o_i,
  input wire logic [WIDTH-1:0] oe_n_i,
  input wire logic [WIDTH-1:0] board_i,
  output logic [WIDTH-1:0] pin_i_o
);
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pin_i_o[i] = oe_n_i[i] ? board_i[i] : pin_o_i[i];
    end
  end
endmodule

// File: verif/test_port_s_p_pin_function_mux.sv
// Purpose: Self-checking bench for the serial and second port pin mux
// Assumes: Zero wait APB slave, pads looped through the board model
// Notes: Pin snapshots are taken seven clocks after a change to let synchronisers settle
`timescale 1ns/1ps
module test_port_s_p_pin_function_mux;
  localparam logic [32:0] ALL = 33'h1ffffffff;
  localparam logic [32:0] M_POE = 33'h038000;
  localparam logic [32:0] M_PO = 33'h007000;
  localparam logic [32:0] M_SOE = 33'h000fc0;
  localparam logic [32:0] M_SO = 33'h00003f;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  psp_pkg::psp_apb_req_type req = '0;
  psp_pkg::psp_apb_rsp_type rsp;
  psp_pkg::psp_periph_out_type per = '0;
  psp_pkg::psp_periph_in_type per_in;
  logic x_mask = 1'b1, ack = 1'b0, ocur = 1'b0, snap = 1'b0;
  logic [5:0] s_in, s_out, s_oen;
  logic [5:0] s_brd = 6'h00;
  logic [2:0] p_in, p_out, p_oen;
  logic [2:0] p_brd = 3'h7;
  logic irq, irq_req, nmi_req, wake;
  logic [32:0] exp_q[$], msk_q[$];
  string nm_q[$];
  int num_errors = 0, checks = 0, cycles = 0;
  logic [31:0] d, e, s;

  always #2.5 clock_i = ~clock_i;

  psp_pin_mux u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp), .periph_i(per),
    .periph_o(per_in), .x_mask_i(x_mask), .irq_ack_i(ack), .overcurrent_i(ocur), .serial_pin_i(s_in),
    .serial_pin_o(s_out), .serial_pin_oe_n_o(s_oen), .second_pin_i(p_in), .second_pin_o(p_out),
    .second_pin_oe_n_o(p_oen), .irq_o(irq), .irq_req_o(irq_req), .nmi_req_o(nmi_req), .wake_o(wake));
  psp_board_model #(.WIDTH(6)) u_ser (.pin_o_i(s_out), .oe_n_i(s_oen), .board_i(s_brd), .pin_i_o(s_in));
  psp_board_model #(.WIDTH(3)) u_sec (.pin_o_i(p_out), .oe_n_i(p_oen), .board_i(p_brd), .pin_i_o(p_in));

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run needs about 300 clocks
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic take(input logic [32:0] seen);
    logic [32:0] ex, m;
    string n;
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("wrong value queue expected none seen %h", seen);
      return;
    end
    ex = exp_q.pop_front();
    m = msk_q.pop_front();
    n = nm_q.pop_front();
    checks++;
    if ((seen & m) !== (ex & m)) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, ex & m, seen & m);
    end
  endtask

  task automatic cmp_read();
    take({rsp.pslverr, rsp.prdata});
  endtask

  task automatic cmp_pin();
    take({2'h0, per_in, irq, irq_req, nmi_req, wake, p_oen, p_out, s_oen, s_out});
  endtask

  always @(posedge clock_i) begin
    if ((req.psel & req.penable & rsp.pready & ~req.pwrite) === 1'b1) begin
      cmp_read();
    end
    if (snap) begin
      cmp_pin();
    end
  end

  task automatic note(input logic [32:0] ex, input logic [32:0] m, input string n);
    exp_q.push_back(ex);
    msk_q.push_back(m);
    nm_q.push_back(n);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock_i);
    req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] ex, input logic [32:0] m, input string n);
    note(ex, m, n);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic pin(input logic [32:0] ex, input logic [32:0] m, input string n);
    repeat (6) @(posedge clock_i);
    note(ex, m, n);
    snap <= 1'b1;
    @(posedge clock_i);
    snap <= 1'b0;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  initial begin
    void'($urandom(32'h50481079));
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    pin({11'h0, 4'h0, 3'h7, 3'h0, 6'h3f, 6'h00}, 33'h3c0000 | M_POE | M_SOE, "reset pins");
    rd(psp_pkg::ROUTE_A_OFS, 33'h0, ALL, "route a");
    rd(psp_pkg::ROUTE_B_OFS, 33'h0, ALL, "route b");
    rd(psp_pkg::IRQ_CTRL_OFS, 33'h0, ALL, "irq ctrl");
    rd(psp_pkg::SER_DIR_OFS, 33'h0, ALL, "ser dir");
    rd(psp_pkg::MASK_OFS, 33'h0, ALL, "mask");
    rd(12'h0fc, {1'b1, 32'h0}, ALL, "unmapped");
    done("reset");
    d = $urandom & 32'h3f;
    e = $urandom & 32'h7;
    wr(psp_pkg::SER_DIR_OFS, 32'h3f);
    wr(psp_pkg::SER_DATA_OFS, d);
    wr(psp_pkg::SEC_DIR_OFS, 32'h7);
    wr(psp_pkg::SEC_DATA_OFS, e);
    pin({11'h0, 4'h0, 3'h0, e[2:0], 6'h00, d[5:0]}, M_POE | M_PO | M_SOE | M_SO, "gpio out");
    rd(psp_pkg::SER_IN_OFS, {1'b0, d}, ALL, "ser input");
    pin({2'h0, 4'h0, d[0], d[1], d[0], d[3], e[0], 22'h0}, 33'h007c00000, "peripheral inputs");
    done("gpio");
    s = $urandom & 32'hf;
    per.spi_en <= 1'b1;
    per.spi_drive <= 4'hf;
    per.spi_out <= s[3:0];
    pin({27'h0, s[0], s[1], s[2], s[3], d[1:0]}, M_SOE | M_SO, "spi lanes");
    pin({2'h0, s[3:0], 27'h0}, 33'h078000000, "spi inputs");
    per.prof_en <= 1'b1;
    per.prof_data <= ~s[0];
    per.prof_clk <= ~s[1];
    pin({27'h0, ~s[0], ~s[1], s[2], s[3], d[1:0]}, M_SO, "pin priority");
    per.prof_en <= 1'b0;
    wr(psp_pkg::ROUTE_A_OFS, 32'h30);
    pin({27'h0, d[5:0]}, M_SO, "spi rerouted");
    wr(psp_pkg::ROUTE_A_OFS, 32'h0);
    per.spi_en <= 1'b0;
    done("spi");
    per.uart1_en <= 1'b1;
    per.uart1_tx <= s[0];
    s_brd[2] <= s[1];
    s_brd[0] <= s[2];
    wr(psp_pkg::ROUTE_A_OFS, 32'h8);
    pin({6'h0, s[1], 16'h0, 2'h1, 4'h0, s[0], 3'h0}, 33'h004000308, "uart rerouted");
    wr(psp_pkg::ROUTE_A_OFS, 32'h0);
    pin({6'h0, s[2], 19'h0, 1'b1, 4'h0, s[0], 1'b0}, 33'h0040000c2, "uart default");
    per.uart1_en <= 1'b0;
    done("uart");
    per.pwm_en <= 3'h7;
    per.pwm <= ~e[2:0];
    wr(psp_pkg::ROUTE_B_OFS, 32'h2);
    pin({18'h0, e[2:0], 12'h0}, M_PO, "pwm unrouted");
    wr(psp_pkg::ROUTE_B_OFS, 32'hb);
    pin({18'h0, ~e[2:0], 12'h0}, M_POE | M_PO, "pwm routed");
    wr(psp_pkg::ROUTE_B_OFS, 32'h0);
    per.pwm_en <= 3'h0;
    done("pwm");
    wr(psp_pkg::SEC_DATA_OFS, 32'h1);
    wr(psp_pkg::STATUS_OFS, 32'h3ff);
    wr(psp_pkg::MISC_OFS, 32'h2);
    ocur <= 1'b1;
    pin(33'h0, 33'h200000, "irq masked");
    rd(psp_pkg::STATUS_OFS, 33'h200, 33'h200, "overcurrent flag");
    wr(psp_pkg::MASK_OFS, 32'h200);
    pin(33'h240000, 33'h240000, "irq raised");
    ocur <= 1'b0;
    repeat (8) @(posedge clock_i);
    wr(psp_pkg::STATUS_OFS, 32'h3ff);
    pin(33'h0, 33'h240000, "irq cleared");
    done("overcurrent");
    wr(psp_pkg::SEC_DIR_OFS, 32'h0);
    wr(psp_pkg::IRQ_CTRL_OFS, 32'h1);
    pin(33'h010000, 33'h110000, "irq idle");
    p_brd[1] <= 1'b0;
    pin(33'h100000, 33'h100000, "irq level");
    p_brd[1] <= 1'b1;
    pin(33'h0, 33'h100000, "irq level gone");
    wr(psp_pkg::IRQ_CTRL_OFS, 32'h3);
    p_brd[1] <= 1'b0;
    repeat (8) @(posedge clock_i);
    p_brd[1] <= 1'b1;
    pin(33'h100000, 33'h100000, "irq edge held");
    ack <= 1'b1;
    @(posedge clock_i);
    ack <= 1'b0;
    pin(33'h0, 33'h100000, "irq acked");
    wr(psp_pkg::IRQ_CTRL_OFS, 32'h0);
    done("maskable");
    p_brd[0] <= 1'b0;
    pin(33'h0, 33'h080000, "nmi before arm");
    x_mask <= 1'b0;
    wr(psp_pkg::SEC_DIR_OFS, 32'h7);
    pin(33'h088000, 33'h088000, "nmi armed");
    p_brd[0] <= 1'b1;
    pin(33'h008000, 33'h088000, "nmi released");
    done("nonmaskable");
    repeat (4) @(posedge clock_i);
    report_and_stop();
  end
endmodule
